// >>> rtl/rwd_cmd_decode.sv
`timescale 1ns/1ps
module rwd_cmd_decode
	import rwd_pkg::*;
(
	// clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst_n,
	// instruction strobes
	input  wire logic   cycle_stb,
	input  wire logic   disable_instr,
	// to the core
	rwd_cmd_if.dec      cmd
);
	logic last_disable_r;

	// remembers whether the previous executed instruction was the disable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_disable_r <= 1'b0;
		end else if (cycle_stb) begin
			last_disable_r <= disable_instr;
		end
	end

	assign cmd.disable_seen          = last_disable_r;
	// only an immediately following restart completes the off pair
	assign cmd.restart_after_disable = cycle_stb & cmd.restart & last_disable_r; // see (R07) (R12)
	assign cmd.off_pair              = cmd.restart_after_disable;
endmodule : rwd_cmd_decode

// >>> rtl/rwd_cmd_if.sv
`timescale 1ns/1ps
interface rwd_cmd_if;
	logic restart;
	logic disable_seen;
	logic off_pair;
	logic restart_after_disable;
	modport dec (input restart, output disable_seen, output off_pair, output restart_after_disable);
	modport core (output restart, input disable_seen, input off_pair, input restart_after_disable);
endinterface : rwd_cmd_if

// >>> rtl/rwd_core.sv
`timescale 1ns/1ps
// Contract
// (R01) After reset release the 16-bit counter loads all ones and counts down once per machine cycle.
// (R02) An underflow from zero sets the first expiry flag.
// (R03) An underflow while the first expiry flag is set sets the second flag and raises the reset signal.
// (R04) The reset signal turns on the pull-down of the reset pin, driving it low.
// (R05) Software must restart the watchdog at least every 65534 machine cycles while it is in use.
// (R06) The reset function is active whenever the enable flag is set.
// (R07) A disable instruction directly followed by a restart clears the enable flag.
// (R08) The enable flag is set on every system reset and on entry to RAM back-up mode.
// (R09) A restart with the first expiry flag set clears it and skips the next instruction.
// (R10) A restart with the first expiry flag clear gives no skip.
// (R11) The skip works even when the reset function is disabled.
// (R12) A disable instruction alone does not stop the watchdog.
// (R13) Entering power-down reinitialises the first expiry flag and the counter.
// (R14) Software should clear the first expiry flag with a restart just before power-down.
// (R15) The watchdog is active again after each return from power-down.
// (R16) After each underflow the counter wraps to all ones and keeps counting.
module rwd_core
	import rwd_pkg::*;
(
	// clock and reset
	input  wire logic   sys_clk,
	input  wire logic   rst_n,
	// instruction stream from the cpu core, one strobe per machine cycle
	input  wire logic   cycle_stb,
	input  wire logic   restart_instr,
	input  wire logic   disable_instr,
	// low-power mode entries
	input  wire logic   power_down_enter,
	input  wire logic   ram_backup_enter,
	// results
	output logic        skip_next,
	output logic        first_expiry_flag,
	output logic        second_expiry_flag,
	output logic        guard_enable_flag,
	output logic        watchdog_reset,
	output logic        reset_pin_oe_n,
	output logic [15:0] guard_down_counter
);
	import rwd_pkg::*;

	// counter helpers, shared by the underflow test and the step
	function automatic logic rwd_at_zero(input logic [15:0] cnt);
		return (cnt == RWD_CNT_ZERO);
	endfunction : rwd_at_zero

	// wraps from zero to all ones by plain modulo arithmetic
	function automatic logic [15:0] rwd_count_down(input logic [15:0] cnt);
		return cnt - 16'h0001;
	endfunction : rwd_count_down

	// the first flag is mirrored by any state past run, except fired once a restart or a power-down has cleared the flag
	function automatic logic rwd_is_armed(input rwd_state_t st);
		return (st != RWD_ST_RUN);
	endfunction : rwd_is_armed

	rwd_cmd_if cmd ();

	// qualified instruction and mode events
	logic       restart_now;
	logic       underflow;
	logic       mode_reinit;
	logic       off_now;

	// reset path
	logic       armed;
	logic       fire;
	rwd_state_t state_r;

	assign cmd.restart = restart_instr;

	// pair detection lives beside the core so it sees every strobe
	rwd_cmd_decode u_dec (
		.sys_clk       (sys_clk),
		.rst_n         (rst_n),
		.cycle_stb     (cycle_stb),
		.disable_instr (disable_instr),
		.cmd           (cmd)
	);

	// a restart only counts when the core really executed it
	assign restart_now = cycle_stb & restart_instr;
	// power-down reloads the counter and clears the first flag
	assign mode_reinit = power_down_enter;
	assign underflow   = cycle_stb & rwd_at_zero(guard_down_counter); // see (R02)
	assign off_now     = cmd.off_pair & cmd.disable_seen; // see (R07) (R12)

	assign armed       = rwd_is_armed(state_r);
	// a restart in the firing strobe cancels it; a reinit wins over all
	assign fire        = underflow & armed & guard_enable_flag & ~restart_now & ~mode_reinit; // see (R03) (R06)

	// counter: restarting does not reload it, only the flag is cleared
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			guard_down_counter <= RWD_CNT_RESET; // see (R01)
		end else if (mode_reinit) begin
			guard_down_counter <= RWD_CNT_RESET; // see (R13) (R15)
		end else if (cycle_stb) begin
			guard_down_counter <= rwd_count_down(guard_down_counter); // see (R01) (R16)
		end else begin
			guard_down_counter <= guard_down_counter;
		end
	end

	// first expiry flag; underflow set beats restart clear
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_expiry_flag <= RWD_FLAG_RESET;
		end else if (mode_reinit) begin
			first_expiry_flag <= RWD_FLAG_RESET; // see (R13)
		end else if (underflow) begin
			first_expiry_flag <= 1'b1; // see (R02)
		end else if (restart_now) begin
			first_expiry_flag <= 1'b0; // see (R09)
		end else begin
			first_expiry_flag <= first_expiry_flag;
		end
	end

	// skip pulse for the next instruction, independent of enable
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			skip_next <= 1'b0;
		end else if (restart_now & first_expiry_flag) begin
			skip_next <= 1'b1; // see (R09) (R11)
		end else begin
			skip_next <= 1'b0; // see (R10)
		end
	end

	// enable flag; a mode entry always brings the guard back
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			guard_enable_flag <= RWD_ENABLE_RESET; // see (R08)
		end else if (ram_backup_enter) begin
			guard_enable_flag <= 1'b1; // see (R08)
		end else if (mode_reinit) begin
			guard_enable_flag <= 1'b1; // see (R15)
		end else if (off_now) begin
			guard_enable_flag <= 1'b0; // see (R07) (R12)
		end else begin
			guard_enable_flag <= guard_enable_flag;
		end
	end

	// reset state: once fired it stays until the system reset comes back
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= RWD_ST_RUN;
		end else begin
			case (state_r)
				RWD_ST_RUN: begin
					// fire cannot happen here, the first flag is still clear
					if (mode_reinit) begin
						state_r <= RWD_ST_RUN;
					end else if (underflow) begin
						state_r <= RWD_ST_ARMED;
					end else begin
						state_r <= RWD_ST_RUN;
					end
				end
				RWD_ST_ARMED: begin
					// same order as the flag: reinit, then set, then clear
					if (fire) begin
						state_r <= RWD_ST_FIRED;
					end else if (mode_reinit) begin
						state_r <= RWD_ST_RUN;
					end else if (underflow) begin
						state_r <= RWD_ST_ARMED;
					end else if (restart_now) begin
						state_r <= RWD_ST_RUN;
					end else begin
						state_r <= RWD_ST_ARMED;
					end
				end
				RWD_ST_FIRED: begin
					// only the system reset leaves this state
					state_r <= RWD_ST_FIRED;
				end
				default: begin
					state_r <= RWD_ST_RUN;
				end
			endcase
		end
	end

	// second expiry flag, sticky until system reset
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			second_expiry_flag <= RWD_FLAG_RESET;
		end else if (fire) begin
			second_expiry_flag <= 1'b1; // see (R03)
		end else begin
			second_expiry_flag <= second_expiry_flag;
		end
	end

	// internal reset request
	// sticky: the pin itself brings the system reset back in
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			watchdog_reset <= RWD_FLAG_RESET;
		end else if (fire) begin
			watchdog_reset <= 1'b1; // see (R03)
		end else begin
			watchdog_reset <= watchdog_reset;
		end
	end

	// pull-down enable of the reset pin, low while pulling
	// open-drain only: the pin is never driven high from here
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_pin_oe_n <= 1'b1;
		end else if (fire) begin
			reset_pin_oe_n <= 1'b0; // see (R04)
		end else begin
			reset_pin_oe_n <= reset_pin_oe_n;
		end
	end
endmodule : rwd_core

// >>> rtl/rwd_pkg.sv
package rwd_pkg;
	localparam int          RWD_CNT_W        = 16;
	localparam logic [15:0] RWD_CNT_RESET    = 16'hFFFF;
	localparam logic [15:0] RWD_CNT_ZERO     = 16'h0000;
	localparam logic        RWD_ENABLE_RESET = 1'b1;
	localparam logic        RWD_FLAG_RESET   = 1'b0;
	localparam int          RWD_SERVICE_MAX  = 65534;

	typedef enum logic [1:0] {
		RWD_ST_RUN   = 2'b00,
		RWD_ST_ARMED = 2'b01,
		RWD_ST_FIRED = 2'b10
	} rwd_state_t;
endpackage : rwd_pkg

// >>> verification/runaway_watchdog_bench.sv
`timescale 1ns/1ps
module runaway_watchdog_bench;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        power_down_enter = 1'b0;
	logic        ram_backup_enter = 1'b0;
	logic        cycle_stb, restart_instr, disable_instr, skip_next, first_expiry_flag;
	logic        second_expiry_flag, guard_enable_flag, watchdog_reset, reset_pin_oe_n;
	logic [15:0] guard_down_counter;
	logic [15:0] exp_cnt = 16'hFFFF;
	int          err_count = 0;
	int          samples_checked = 0;
	always #25 sys_clk = ~sys_clk;
	rwd_cpu_model CPU (.sys_clk(sys_clk), .cycle_stb(cycle_stb), .restart_instr(restart_instr),
		.disable_instr(disable_instr));
	rwd_core DUT (
		.sys_clk            (sys_clk),
		.rst_n              (rst_n),
		.cycle_stb          (cycle_stb),
		.restart_instr      (restart_instr),
		.disable_instr      (disable_instr),
		.power_down_enter   (power_down_enter),
		.ram_backup_enter   (ram_backup_enter),
		.skip_next          (skip_next),
		.first_expiry_flag  (first_expiry_flag),
		.second_expiry_flag (second_expiry_flag),
		.guard_enable_flag  (guard_enable_flag),
		.watchdog_reset     (watchdog_reset),
		.reset_pin_oe_n     (reset_pin_oe_n),
		.guard_down_counter (guard_down_counter)
	);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic step(input logic rs, input logic ds, input int n);
		CPU.run(rs, ds, n);
		exp_cnt -= 16'(n);
		#1;
	endtask : step
	task automatic pulse(input logic backup);
		@(posedge sys_clk);
		if (backup) ram_backup_enter <= 1'b1;
		else power_down_enter <= 1'b1;
		@(posedge sys_clk);
		{power_down_enter, ram_backup_enter} <= 2'b00;
		#1;
	endtask : pulse
	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		#1;
		chk(guard_down_counter, 16'hFFFF);
		chk(guard_enable_flag, 1'b1);
		chk(reset_pin_oe_n, 1'b1);
		chk(first_expiry_flag, 1'b0);
		chk(second_expiry_flag, 1'b0);
		chk(watchdog_reset, 1'b0);
		chk(skip_next, 1'b0);
		$display("reset test done");
		step(1'b1, 1'b0, 3);
		chk(skip_next, 1'b0);
		chk(guard_down_counter, exp_cnt);
		step(1'b0, 1'b1, 1);
		step(1'b0, 1'b0, 1);
		step(1'b1, 1'b0, 1);
		chk(guard_enable_flag, 1'b1);
		step(1'b0, 1'b1, 1);
		step(1'b1, 1'b0, 1);
		chk(guard_enable_flag, 1'b0);
		$display("disable test done");
		step(1'b0, 1'b0, int'(exp_cnt));
		chk(guard_down_counter, 16'h0000);
		step(1'b0, 1'b0, 1);
		chk(first_expiry_flag, 1'b1);
		chk(guard_down_counter, 16'hFFFF);
		chk(watchdog_reset, 1'b0);
		chk(second_expiry_flag, 1'b0);
		chk(reset_pin_oe_n, 1'b1);
		step(1'b1, 1'b0, 1);
		chk(skip_next, 1'b1);
		chk(first_expiry_flag, 1'b0);
		step(1'b0, 1'b0, 1);
		chk(skip_next, 1'b0);
		$display("underflow test done");
		pulse(1'b0);
		chk(guard_down_counter, 16'hFFFF);
		chk(first_expiry_flag, 1'b0);
		chk(guard_enable_flag, 1'b1);
		step(1'b0, 1'b1, 1);
		step(1'b1, 1'b0, 1);
		chk(guard_enable_flag, 1'b0);
		pulse(1'b1);
		chk(guard_enable_flag, 1'b1);
		$display("mode test done");
		print_verdict();
	end
	initial begin
		#(50 * 70000);
		err_count++;
		print_verdict();
	end
endmodule : runaway_watchdog_bench
bind rwd_core rwd_core_sva u_sva (
	.sys_clk            (sys_clk),
	.rst_n              (rst_n),
	.cycle_stb          (cycle_stb),
	.restart_instr      (restart_instr),
	.disable_instr      (disable_instr),
	.power_down_enter   (power_down_enter),
	.ram_backup_enter   (ram_backup_enter),
	.skip_next          (skip_next),
	.first_expiry_flag  (first_expiry_flag),
	.second_expiry_flag (second_expiry_flag),
	.guard_enable_flag  (guard_enable_flag),
	.watchdog_reset     (watchdog_reset),
	.reset_pin_oe_n     (reset_pin_oe_n),
	.guard_down_counter (guard_down_counter)
);

// >>> verification/rwd_core_sva.sv
`timescale 1ns/1ps
module rwd_core_sva (
	// watched ports
	input wire logic        sys_clk, rst_n, cycle_stb, restart_instr, disable_instr,
	input wire logic        power_down_enter, ram_backup_enter, skip_next, first_expiry_flag,
	input wire logic        second_expiry_flag, guard_enable_flag, watchdog_reset, reset_pin_oe_n,
	input wire logic [15:0] guard_down_counter
);
	logic dis_r;
	logic st;
	// power-down reinits and both mode entries set the enable flag, so they are kept out of plain steps
	assign st = cycle_stb && !power_down_enter && !ram_backup_enter;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) dis_r <= 1'b0;
		else if (cycle_stb) dis_r <= disable_instr;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_count_step: assert property (st && guard_down_counter != 16'h0000 |=>
		guard_down_counter == $past(guard_down_counter) - 16'h0001) else $error("bad step");
	a_underflow_wrap: assert property (st && guard_down_counter == 16'h0000 |=>
		first_expiry_flag && guard_down_counter == 16'hFFFF) else $error("bad underflow");
	a_second_fire: assert property (st && guard_down_counter == 16'h0000 && first_expiry_flag
		&& guard_enable_flag && !restart_instr |=> second_expiry_flag && watchdog_reset) else $error("no fire");
	a_pin_pulldown: assert property (reset_pin_oe_n == !watchdog_reset) else $error("bad pin");
	a_skip_clear: assert property (st && restart_instr && first_expiry_flag
		&& guard_down_counter != 16'h0000 |=> skip_next && !first_expiry_flag) else $error("no skip");
	a_no_skip: assert property (st && restart_instr && !first_expiry_flag |=> !skip_next)
		else $error("stray skip");
	a_off_pair: assert property (st && restart_instr && dis_r |=> !guard_enable_flag)
		else $error("pair ignored");
	a_backup_enable: assert property (ram_backup_enter |=> guard_enable_flag) else $error("no enable");
	a_pd_reinit: assert property (power_down_enter |=>
		guard_down_counter == 16'hFFFF && !first_expiry_flag && guard_enable_flag) else $error("no reinit");
	a_lone_disable: assert property (st && !(restart_instr && dis_r) |=>
		guard_enable_flag == $past(guard_enable_flag)) else $error("enable lost");
endmodule : rwd_core_sva

// >>> verification/rwd_cpu_model.sv
`timescale 1ns/1ps
module rwd_cpu_model (
	// clock
	input wire logic sys_clk,
	// instruction strobes
	output logic     cycle_stb,
	output logic     restart_instr,
	output logic     disable_instr
);
	initial {cycle_stb, restart_instr, disable_instr} = 3'b000;
	// n instructions back to back, then one idle cycle so pairs stay adjacent strobes
	task automatic run(input logic rs, input logic ds, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			{cycle_stb, restart_instr, disable_instr} <= {1'b1, rs, ds};
		end
		@(posedge sys_clk);
		{cycle_stb, restart_instr, disable_instr} <= 3'b000;
	endtask : run
endmodule : rwd_cpu_model
